/* bcd_calendar_clock.sv */
`timescale 1ns/10ps
`include "rtc_consts.svh"

// Overview of operation
// [RQ1] Supply low: serial access to registers refused.
// [RQ2] Supply back: access waits a recovery interval.
// [RQ3] First power: 01/01/00, weekday 01, 00:00:00.
// [RQ4] First power clears the oscillator halt bit.
// [RQ5] Clock at 00h-07h, user memory 08h-3Fh.
// [RQ6] Pointer wraps from 3Fh to 00h.
// [RQ7] Start, stop, wrap copy time to buffer.
// [RQ8] Time fields are packed decimal digits.
// [RQ9] Halt bit stops the oscillator and counting.
// [RQ10] Weekday 1-7 advances at each midnight.
// [RQ11] Seconds write restarts the sub-second chain.
// [RQ12] Written byte lands when acknowledge is driven.
// [RQ13] Master finishes time writes within one second.
// [RQ14] 1Hz output rises 500ms after seconds write.
// [RQ15] Hours bit 6 selects 12-hour counting.
// [RQ16] Bit 5: afternoon, or tens digit 20-23.
// [RQ17] Master rewrites hours after changing format.
// [RQ18] Master writes only valid time values.
// [RQ19] Fixed-zero bits always read as zero.
// [RQ20] Each field counts within its own range.
// [RQ21] Month lengths and leap February honoured.
// [RQ22] First byte sets pointer; each byte advances it.
// [RQ23] Rate bits pick 1Hz, 4k, 8k, 32k output.
// [RQ24] Stopped flag sticky, cleared only by zero.
// [RQ25] Output disabled: pin shows idle-level bit.
module bcd_calendar_clock
   import rtc_pkg::*;
#(
   parameter int REC_CYCLES = `REC_CYCLES
) (
   // Clocks and reset
   input  wire logic i_ref_clk,
   input  wire logic i_xtal_clk,
   input  wire logic i_nrst,
   // Supply monitor
   input  wire logic i_vcc_ok,
   // Serial bus
   input  wire logic i_scl,
   input  wire logic i_sda_i,
   output logic      o_sda_o,
   output logic      o_sda_oe,
   // Square wave pin
   output logic      o_sqw_o,
   output logic      o_sqw_oe
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   logic        scl_s, sda_s, vcc_s, scl_p_q, sda_p_q;
   bus_state_e  st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sr_q, tx_q, ctrl_q;
   logic [5:0]  ptr_q;
   logic        rw_q, first_q, acc_q, secw_q, tick_p_q;
   logic [19:0] rec_q;
   time_s       tm_q, sh_q, tm_nx;
   logic [7:0]  ram [`RAM_FIRST:`RAM_LAST];
   logic        tick_s, s1hz, s4k, s8k, s32k;
   logic        halt_x, secw_x, secw_p_q, tp_q, tn_q, tick_t_q;
   logic [14:0] pc_q;

   // -------------------------------------------------------------------
   // Pin and cross-domain synchronisers
   // -------------------------------------------------------------------
   sync_3ff #(.RST_VAL(1'b1)) u_scl (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(i_scl), .o_q(scl_s));
   sync_3ff #(.RST_VAL(1'b1)) u_sda (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(i_sda_i), .o_q(sda_s));
   sync_3ff #(.RST_VAL(1'b0)) u_vcc (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(i_vcc_ok), .o_q(vcc_s));
   sync_3ff #(.RST_VAL(1'b0)) u_tick (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(tick_t_q), .o_q(tick_s));
   sync_3ff #(.RST_VAL(1'b0)) u_1hz (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(pc_q[14]), .o_q(s1hz));
   sync_3ff #(.RST_VAL(1'b0)) u_4k (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(pc_q[2]), .o_q(s4k));
   sync_3ff #(.RST_VAL(1'b0)) u_8k (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(pc_q[1]), .o_q(s8k));
   sync_3ff #(.RST_VAL(1'b0)) u_32k (.i_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_d(tp_q ^ tn_q), .o_q(s32k));
   sync_3ff #(.RST_VAL(1'b0)) u_halt (.i_clk(i_xtal_clk), .i_nrst(i_nrst),
      .i_d(tm_q.sec[`HALT_BIT]), .o_q(halt_x));
   sync_3ff #(.RST_VAL(1'b0)) u_secw (.i_clk(i_xtal_clk), .i_nrst(i_nrst),
      .i_d(secw_q), .o_q(secw_x));

   // -------------------------------------------------------------------
   // Bus event decode
   // -------------------------------------------------------------------
   wire       start_ev  = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire       stop_ev   = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire       scl_rise  = scl_s & ~scl_p_q;
   wire       scl_fall  = ~scl_s & scl_p_q;
   wire       byte_done = scl_fall & (bit_q == 4'h8);
   wire       addr_hit  = (sr_q[7:1] == `SLAVE_ADDR) & acc_q;
   wire       wr_commit = (st_q == ST_WDATA) & byte_done & ~first_q;
   wire       rd_done   = (st_q == ST_RDATA) & byte_done;
   wire       ptr_inc   = wr_commit | rd_done;
   wire       wrap_ev   = ptr_inc & (ptr_q == `RAM_LAST);
   wire [5:0] bsel      = {ptr_q[2:0], 3'b000};
   wire       is_clk    = (ptr_q < `RAM_FIRST);
   wire       is_time   = (ptr_q < `REG_CTRL);
   wire [63:0] wmask_all = `WMASK_VEC;
   wire [7:0] wmask     = wmask_all[bsel +: 8];
   wire [7:0] wdata     = sr_q & wmask;
   wire       sec_wr    = wr_commit & (ptr_q == `REG_SEC);
   wire       ctrl_wr   = wr_commit & (ptr_q == `REG_CTRL);

   // Reads of time come from the buffered copy; zero bits stay zero.
   wire [7:0] sh_byte   = sh_q[bsel +: 8];
   wire [7:0] clk_byte  = is_time ? sh_byte : ctrl_q;
   wire [7:0] rd_data   = is_clk ? clk_byte : ram[ptr_q];  // see RQ5

   // -------------------------------------------------------------------
   // Serial target state machine
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q     <= ST_IDLE;
         bit_q    <= 4'h0;
         sr_q     <= 8'h00;
         tx_q     <= 8'h00;
         ptr_q    <= 6'h00;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         o_sda_oe <= 1'b0;
      end else if (start_ev) begin
         st_q     <= ST_ADDR;
         bit_q    <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (stop_ev || !acc_q) begin
         st_q     <= ST_IDLE;                     // see RQ1
         o_sda_oe <= 1'b0;
      end else begin
         if (scl_rise) begin
            sr_q  <= {sr_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
         end
         case (st_q)
            ST_ADDR: begin
               if (byte_done) begin
                  st_q     <= addr_hit ? ST_AACK : ST_IDLE;  // see RQ1
                  o_sda_oe <= addr_hit;
                  rw_q     <= sr_q[0];
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bit_q    <= 4'h0;
                  first_q  <= ~rw_q;
                  st_q     <= rw_q ? ST_RDATA : ST_WDATA;
                  o_sda_oe <= rw_q & ~rd_data[7];
                  tx_q     <= {rd_data[6:0], 1'b1};
               end
            end
            ST_WDATA: begin
               if (byte_done) begin
                  st_q     <= ST_WACK;
                  o_sda_oe <= 1'b1;
                  first_q  <= 1'b0;
                  if (first_q) begin
                     ptr_q <= sr_q[5:0];                // see RQ22
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  st_q     <= ST_WDATA;
                  o_sda_oe <= 1'b0;
                  bit_q    <= 4'h0;
               end
            end
            ST_RDATA: begin
               if (byte_done) begin
                  st_q     <= ST_RACK;
                  o_sda_oe <= 1'b0;
               end else if (scl_fall) begin
                  o_sda_oe <= ~tx_q[7];
                  tx_q     <= {tx_q[6:0], 1'b1};
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  bit_q    <= 4'h0;
                  st_q     <= sr_q[0] ? ST_IDLE : ST_RDATA;
                  o_sda_oe <= ~sr_q[0] & ~rd_data[7];
                  tx_q     <= {rd_data[6:0], 1'b1};
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
         if (ptr_inc) begin
            ptr_q <= ptr_q + 6'h01;                   // see RQ6, RQ22
         end
      end
   end

   // -------------------------------------------------------------------
   // Supply gating and line history
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rec_q   <= 20'h00000;
         acc_q   <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         if (!vcc_s) begin
            rec_q <= 20'h00000;                       // see RQ1
            acc_q <= 1'b0;
         end else if (rec_q < 20'(REC_CYCLES)) begin
            rec_q <= rec_q + 20'h00001;               // see RQ2
         end else begin
            acc_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Time counting chain
   // -------------------------------------------------------------------
   logic [7:0] sec_n, min_n, hr_n, wd_n, md_n, mo_n, yr_n, mdays;
   logic       sec_w, min_w, hr_w, wd_w, md_w, mo_w, yr_w;
   wire        h12    = tm_q.hour[`HR12_BIT];            // see RQ15
   wire        pm     = tm_q.hour[`PM_BIT];
   wire [7:0]  hv     = h12 ? {3'b000, tm_q.hour[4:0]}
                            : {2'b00, tm_q.hour[5:0]};   // see RQ16
   wire [7:0]  hr_lo  = h12 ? `BCD_ONE : `BCD_ZERO;
   wire [7:0]  hr_hi  = h12 ? `HR12_MAX : `HR24_MAX;
   wire        noon   = (hv == `HR_PRE_NOON);
   wire        day_c  = h12 ? (noon & pm) : hr_w;
   wire        leap   = tm_q.year[1:0] == (tm_q.year[4] ? 2'b10 : 2'b00);
   wire        m30    = (tm_q.mon == `MON_APR) | (tm_q.mon == `MON_JUN) |
                        (tm_q.mon == `MON_SEP) | (tm_q.mon == `MON_NOV);
   wire        c1     = sec_w;
   wire        c2     = c1 & min_w;
   wire        c3     = c2 & day_c;
   wire        c4     = c3 & md_w;
   wire        c5     = c4 & mo_w;

   // Month length with leap February.
   assign mdays = (tm_q.mon == `MON_FEB) ? (leap ? `DAYS_29 : `DAYS_28) :
                  m30 ? `DAYS_30 : `DAYS_31;              // see RQ21

   bcd_step u_sec (.i_val({1'b0, tm_q.sec[6:0]}), .i_lo(`BCD_ZERO),
      .i_hi(`SEC_MAX), .o_nxt(sec_n), .o_wrap(sec_w));
   bcd_step u_min (.i_val(tm_q.min), .i_lo(`BCD_ZERO), .i_hi(`SEC_MAX),
      .o_nxt(min_n), .o_wrap(min_w));
   bcd_step u_hr (.i_val(hv), .i_lo(hr_lo), .i_hi(hr_hi),
      .o_nxt(hr_n), .o_wrap(hr_w));
   bcd_step u_wd (.i_val(tm_q.wday), .i_lo(`BCD_ONE), .i_hi(`WDAY_MAX),
      .o_nxt(wd_n), .o_wrap(wd_w));
   bcd_step u_md (.i_val(tm_q.mday), .i_lo(`BCD_ONE), .i_hi(mdays),
      .o_nxt(md_n), .o_wrap(md_w));
   bcd_step u_mo (.i_val(tm_q.mon), .i_lo(`BCD_ONE), .i_hi(`MON_MAX),
      .o_nxt(mo_n), .o_wrap(mo_w));
   bcd_step u_yr (.i_val(tm_q.year), .i_lo(`BCD_ZERO), .i_hi(`YEAR_MAX),
      .o_nxt(yr_n), .o_wrap(yr_w));

   // Next time after one second, all digits packed decimal.
   assign tm_nx.sec  = {tm_q.sec[`HALT_BIT], sec_n[6:0]}; // see RQ8, RQ20
   assign tm_nx.min  = c1 ? min_n : tm_q.min;
   assign tm_nx.hour = !c2 ? tm_q.hour :
                       h12 ? {2'b01, pm ^ noon, hr_n[4:0]}
                           : {2'b00, hr_n[5:0]};
   assign tm_nx.wday = c3 ? wd_n : tm_q.wday;             // see RQ10
   assign tm_nx.mday = c3 ? md_n : tm_q.mday;
   assign tm_nx.mon  = c4 ? mo_n : tm_q.mon;
   assign tm_nx.year = c5 ? yr_n : tm_q.year;

   wire sec_tick = tick_s ^ tick_p_q;
   wire tick_en  = sec_tick & ~tm_q.sec[`HALT_BIT];      // see RQ9
   wire halt_rise = sec_wr & wdata[`HALT_BIT] & ~tm_q.sec[`HALT_BIT];
   wire stop_old = ctrl_q[`STOP_BIT];
   // The mask drops the flag bit, so the raw bit decides: a one is ignored.
   wire stop_d   = halt_rise | (ctrl_wr ? (stop_old & sr_q[`STOP_BIT])
                                        : stop_old);       // see RQ24
   wire [7:0] ctrl_d = ctrl_wr ? wdata : ctrl_q;

   // Live time, buffered copy and control byte.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tm_q     <= {`RST_YEAR, `RST_MON, `RST_MDAY, `RST_WDAY,
                      `RST_HOUR, `RST_MIN, `RST_SEC};  // see RQ3, RQ4
         sh_q     <= {`RST_YEAR, `RST_MON, `RST_MDAY, `RST_WDAY,
                      `RST_HOUR, `RST_MIN, `RST_SEC};
         ctrl_q   <= `RST_CTRL;
         secw_q   <= 1'b0;
         tick_p_q <= 1'b0;
      end else begin
         tick_p_q <= tick_s;
         if (wr_commit && is_time) begin
            tm_q[bsel +: 8] <= wdata;              // see RQ12, RQ19
         end else if (tick_en) begin
            tm_q <= tm_nx;
         end
         if (start_ev || stop_ev || wrap_ev) begin
            sh_q <= tm_q;                             // see RQ7
         end
         ctrl_q <= {ctrl_d[7:6], stop_d, ctrl_d[4:0]};
         if (sec_wr) begin
            secw_q <= ~secw_q;                        // see RQ11
         end
      end
   end

   // User memory holds whatever was written; it has no reset.
   always_ff @(posedge i_ref_clk) begin
      if (wr_commit && !is_clk) begin
         ram[ptr_q] <= sr_q;                          // see RQ5
      end
   end

   // -------------------------------------------------------------------
   // Crystal domain: sub-second chain and rate sources
   // -------------------------------------------------------------------
   always_ff @(posedge i_xtal_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_q     <= 15'h0000;
         secw_p_q <= 1'b0;
         tick_t_q <= 1'b0;
         tp_q     <= 1'b0;
      end else begin
         secw_p_q <= secw_x;
         if (secw_x != secw_p_q) begin
            pc_q <= 15'h0000;                         // see RQ11, RQ14
         end else if (!halt_x) begin
            pc_q <= pc_q + 15'h0001;
            if (pc_q == `PRESC_LAST) begin
               tick_t_q <= ~tick_t_q;
            end
         end
         if (!halt_x) begin
            tp_q <= ~tp_q;
         end
      end
   end

   // Falling-edge copy so that tp xor tn follows the crystal clock.
   always_ff @(negedge i_xtal_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tn_q <= 1'b0;
      end else begin
         tn_q <= tp_q;
      end
   end

   // -------------------------------------------------------------------
   // Square wave pin
   // -------------------------------------------------------------------
   wire [3:0] rate_src = {s32k, s8k, s4k, s1hz};
   wire       sqw_lvl  = ctrl_q[`SQON_BIT] ? rate_src[ctrl_q[1:0]]
                                            : ctrl_q[`OUT_BIT];

   // Open drain: pull low whenever the wanted level is low.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sqw_oe <= 1'b0;
         o_sqw_o  <= 1'b0;
         o_sda_o  <= 1'b0;
      end else begin
         o_sqw_oe <= ~sqw_lvl;                        // see RQ23, RQ25
         o_sqw_o  <= 1'b0;
         o_sda_o  <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_ack_needs_access: assert property ( // see RQ1
      @(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(st_q == ST_AACK) |-> $past(acc_q))
      else $error("Address acknowledged while access blocked.");

   a_recovery_hold: assert property ( // see RQ2
      @(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(vcc_s) |-> !acc_q [*8])
      else $error("Access opened before recovery interval.");

   a_ptr_wrap: assert property ( // see RQ6
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (ptr_inc && ptr_q == `RAM_LAST) |=> (ptr_q == 6'h00))
      else $error("Pointer did not wrap to zero.");

   a_snap_copy: assert property ( // see RQ7
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (start_ev || stop_ev || wrap_ev) |=> (sh_q == $past(tm_q)))
      else $error("Buffer not loaded on bus event.");

   a_halt_holds: assert property ( // see RQ9
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (tm_q.sec[`HALT_BIT] && !wr_commit) |=> $stable(tm_q.sec[6:0]))
      else $error("Seconds moved while halted.");

   a_chain_kick: assert property ( // see RQ11
      @(posedge i_ref_clk) disable iff (!i_nrst)
      sec_wr |=> (secw_q != $past(secw_q)))
      else $error("Seconds write did not restart chain.");

   a_commit_at_ack: assert property ( // see RQ12
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (wr_commit && ptr_q == `REG_MIN) |=>
         (tm_q.min == $past(wdata)) && o_sda_oe)
      else $error("Minutes not committed with acknowledge.");

   a_zero_bits: assert property ( // see RQ19
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (ptr_q == `REG_WDAY) |-> (rd_data[7:3] == 5'h00))
      else $error("Fixed-zero weekday bits read nonzero.");

   a_osf_set: assert property ( // see RQ24
      @(posedge i_ref_clk) disable iff (!i_nrst)
      halt_rise |=> ctrl_q[`STOP_BIT])
      else $error("Stopped flag not set on halt.");

   a_idle_level: assert property ( // see RQ25
      @(posedge i_ref_clk) disable iff (!i_nrst)
      !ctrl_q[`SQON_BIT] |=> (o_sqw_oe == !$past(ctrl_q[`OUT_BIT])))
      else $error("Idle pin level does not follow control.");

endmodule : bcd_calendar_clock

/* bcd_step.sv */
`timescale 1ns/10ps

module bcd_step (
   // Current value and its range
   input  wire logic [7:0] i_val,
   input  wire logic [7:0] i_lo,
   input  wire logic [7:0] i_hi,
   // Next value and range wrap
   output logic [7:0]      o_nxt,
   output logic            o_wrap
);

   wire [7:0] tens_up = {i_val[7:4] + 4'h1, 4'h0};
   wire [7:0] ones_up = i_val + 8'h01;

   // Packed decimal increment that wraps from the top back to the floor.
   assign o_wrap = (i_val == i_hi);
   assign o_nxt  = o_wrap ? i_lo :
                   (i_val[3:0] == 4'h9) ? tens_up : ones_up;

endmodule : bcd_step

/* bus_master.sv */
`timescale 1ns/10ps

module bus_master (
   // Clock used to pace the bus
   input  wire logic i_clk,
   // Bus lines
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   // Bus idles with both lines released high.
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // Third of a bit: ten reference cycles, moved just after an edge.
   task automatic hp;
      repeat (10) @(posedge i_clk);
      #1;
   endtask : hp

   // Data falls while clock high; also a repeated start.
   task automatic start;
      o_sda = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda = 1'b0;
      hp();
      o_scl = 1'b0;
      hp();
   endtask : start

   // Data rises while clock high.
   task automatic stop;
      o_sda = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda = 1'b1;
      hp();
   endtask : stop

   // Data is set in the low phase and sampled in the high phase.
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      hp();
      o_scl = 1'b1;
      hp();
      r = i_sda;
      o_scl = 1'b0;
      hp();
   endtask : bit_io

   // Eight bits, most significant first, then the ninth bit m.
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] q, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(m, r);
      a = !r;
   endtask : xfer
endmodule : bus_master

/* rtc_consts.svh */
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_SEC        6'h00
`define REG_MIN        6'h01
`define REG_HOUR       6'h02
`define REG_WDAY       6'h03
`define REG_MDAY       6'h04
`define REG_MON        6'h05
`define REG_YEAR       6'h06
`define REG_CTRL       6'h07
`define RAM_FIRST      6'h08
`define RAM_LAST       6'h3F

// ----------------------------------------------------------------------
// Field positions and writable bits (byte 0 in the low lane)
// ----------------------------------------------------------------------
`define HALT_BIT       7
`define HR12_BIT       6
`define PM_BIT         5
`define OUT_BIT        7
`define STOP_BIT       5
`define SQON_BIT       4
`define WMASK_VEC      64'h93FF1F3F077F7FFF

// ----------------------------------------------------------------------
// First-power values
// ----------------------------------------------------------------------
`define RST_SEC        8'h00
`define RST_MIN        8'h00
`define RST_HOUR       8'h00
`define RST_WDAY       8'h01
`define RST_MDAY       8'h01
`define RST_MON        8'h01
`define RST_YEAR       8'h00
`define RST_CTRL       8'hB3

// ----------------------------------------------------------------------
// Counting limits in packed decimal
// ----------------------------------------------------------------------
`define BCD_ZERO       8'h00
`define BCD_ONE        8'h01
`define SEC_MAX        8'h59
`define HR24_MAX       8'h23
`define HR12_MAX       8'h12
`define HR_PRE_NOON    8'h11
`define WDAY_MAX       8'h07
`define MON_MAX        8'h12
`define YEAR_MAX       8'h99
`define MON_FEB        8'h02
`define MON_APR        8'h04
`define MON_JUN        8'h06
`define MON_SEP        8'h09
`define MON_NOV        8'h11
`define DAYS_28        8'h28
`define DAYS_29        8'h29
`define DAYS_30        8'h30
`define DAYS_31        8'h31

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_MHZ    25
`define REC_TIME_NS    2000000
`define REC_CYCLES     ((`REC_TIME_NS * `REF_CLK_MHZ) / 1000)
`define PRESC_LAST     15'h7FFF

// Bus address of this target; the value is arbitrary.
`define SLAVE_ADDR     7'h2A

`endif

/* rtc_pkg.sv */
package rtc_pkg;

   // Live or buffered time, one byte per location, seconds lowest.
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] mon;
      logic [7:0] mday;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } time_s;

   // Serial target states.
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_AACK  = 7'h04,
      ST_WDATA = 7'h08,
      ST_WACK  = 7'h10,
      ST_RDATA = 7'h20,
      ST_RACK  = 7'h40
   } bus_state_e;

endpackage : rtc_pkg

/* sync_3ff.sv */
`timescale 1ns/10ps

module sync_3ff #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_nrst,
   // Data
   input  wire logic i_d,
   output logic      o_q
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Three stages; the output follows only once stages two and three agree.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         o_q  <= RST_VAL;
      end else begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_q <= s3_q;
         end
      end
   end

endmodule : sync_3ff

/* tb.sv */
`timescale 1ns/10ps
`include "rtc_consts.svh"

module tb;
   import rtc_pkg::*;
   logic       i_ref_clk  = 1'b0;
   logic       i_xtal_clk = 1'b0;
   logic       i_nrst     = 1'b0;
   logic       i_vcc_ok   = 1'b1;
   logic       scl, sdam, o_sda_oe, o_sqw_oe, sda_o, sqw_o;
   logic [7:0] q;
   logic       a;
   int         error_cnt   = 0;
   int         comparisons = 0;
   // The data line is pulled up unless a party pulls it low.
   wire        sda = sdam & (o_sda_oe ? sda_o : 1'b1);

   // Reference clock, and a crystal clock with an odd phase.
   always #20 i_ref_clk = !i_ref_clk;
   initial begin
      #7;
      forever #40 i_xtal_clk = !i_xtal_clk;
   end

   bus_master i_bus_master (.i_clk(i_ref_clk), .i_sda(sda),
      .o_scl(scl), .o_sda(sdam));
   bcd_calendar_clock #(.REC_CYCLES(1000)) i_bcd_calendar_clock (
      .i_ref_clk(i_ref_clk), .i_xtal_clk(i_xtal_clk), .i_nrst(i_nrst),
      .i_vcc_ok(i_vcc_ok), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o),
      .o_sda_oe(o_sda_oe), .o_sqw_o(sqw_o), .o_sqw_oe(o_sqw_oe));

   // Compares one value and counts it.
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic x(input logic [7:0] d, input logic m);
      i_bus_master.xfer(d, m, q, a);
   endtask : x

   // Addresses the target for writing and checks its acknowledge.
   task automatic open_w(input logic e);
      i_bus_master.start();
      x({`SLAVE_ADDR, 1'b0}, 1'b1);
      check("address ack", {7'h0, a}, {7'h0, e});
   endtask : open_w

   task automatic wr(input logic [5:0] p, input logic [7:0] d[$]);
      open_w(1'b1);
      x({2'h0, p}, 1'b1);
      check("pointer ack", {7'h0, a}, 8'h01);
      foreach (d[i]) begin
         x(d[i], 1'b1);
         check("data ack", {7'h0, a}, 8'h01);
      end
      i_bus_master.stop();
   endtask : wr

   // Sets the pointer, then reads with a repeated start.
   task automatic rd(input logic [5:0] p, input logic [7:0] e[$]);
      open_w(1'b1);
      x({2'h0, p}, 1'b1);
      i_bus_master.start();
      x({`SLAVE_ADDR, 1'b1}, 1'b1);
      foreach (e[i]) begin
         x(8'hFF, i == e.size() - 1);
         check("read byte", q, e[i]);
      end
      i_bus_master.stop();
   endtask : rd

   task automatic summarize;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize

   // The tests take about 90000 cycles; 4 ms leaves a margin.
   initial begin
      #4ms;
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (2) @(posedge i_ref_clk);
      #1 i_nrst = 1'b1;
      repeat (1100) @(posedge i_ref_clk);
      #1;
      rd(6'h00, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00,
                  8'hB3});
      $display("test first power values done");
      wr(6'h3F, '{8'h5A, 8'h45, 8'h59});
      rd(6'h3F, '{8'h5A, 8'h45, 8'h59});
      $display("test pointer wrap done");
      wr(6'h07, '{8'h00});
      rd(6'h07, '{8'h00});
      check("pin pulled", {7'h0, o_sqw_oe}, 8'h01);
      wr(6'h07, '{8'hA0});
      rd(6'h07, '{8'h80});
      check("pin pulled", {7'h0, o_sqw_oe}, 8'h00);
      $display("test control done");
      i_vcc_ok = 1'b0;
      repeat (10) @(posedge i_ref_clk);
      #1;
      open_w(1'b0);
      i_bus_master.stop();
      i_vcc_ok = 1'b1;
      open_w(1'b0);
      i_bus_master.stop();
      repeat (1100) @(posedge i_ref_clk);
      #1;
      rd(6'h07, '{8'h80});
      $display("test supply gating done");
      // Halting sets the stopped flag; a one written to it keeps it set.
      wr(6'h00, '{8'h80});
      rd(6'h07, '{8'hA0});
      wr(6'h07, '{8'h30});
      rd(6'h07, '{8'h30});
      $display("test oscillator halt done");
      // Valid 11:59:59 PM Saturday, 28 Feb 01, written at once.
      wr(6'h00, '{8'h59, 8'h59, 8'h71, 8'h07, 8'h28, 8'h02,
                  8'h01});
      // The 1Hz output stays low until half a second after the write.
      repeat (30000) @(posedge i_ref_clk);
      #1 check("square pin", {6'h0, o_sqw_oe, sqw_o}, 8'h02);
      repeat (2000) @(posedge i_ref_clk);
      #1 check("square pin", {6'h0, o_sqw_oe, sqw_o}, 8'h00);
      repeat (34000) @(posedge i_ref_clk);
      #1;
      rd(6'h00, '{8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h03,
                  8'h01});
      $display("test midnight rollover done");
      summarize();
   end
endmodule : tb
